// ==== src/sbp_pkg.sv ====
// Package of register map, reset values and timing constants for the brake sequencer
package sbp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PHASE_LOSS   = 8'h00;
  localparam logic [7:0] OFS_CMD_DELAY    = 8'h04;
  localparam logic [7:0] OFS_ZERO_SPEED   = 8'h08;
  localparam logic [7:0] OFS_HOLD         = 8'h0c;
  localparam logic [7:0] OFS_MAX_WAIT     = 8'h10;
  localparam logic [7:0] OFS_CONTROL      = 8'h14;
  localparam logic [7:0] OFS_STATUS       = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h20;
  // Reset values
  localparam logic [15:0] RST_PHASE_LOSS  = 16'h0003;
  localparam logic [15:0] RST_CMD_DELAY   = 16'h00fa;
  localparam logic [15:0] RST_ZERO_SPEED  = 16'h001e;
  localparam logic [15:0] RST_HOLD        = 16'h0096;
  localparam logic [15:0] RST_MAX_WAIT    = 16'h01f4;
  // Field positions
  localparam int BIT_OUT_PHASE  = 0;
  localparam int BIT_IN_PHASE   = 1;
  localparam int BIT_BRAKE_MAP  = 0;
  // Interrupt bits: 0 overheat, 1 brake locked, 2 commands accepted
  localparam int IRQ_W          = 3;
  // Timing
  localparam int CLK_HZ         = 125_000_000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int STATIC_RPM     = 20;
  localparam int DYN_HOLD_MS    = 50;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_ON      = 3'b001,
    ST_HOLD    = 3'b010,
    ST_DYNWAIT = 3'b011
  } sbp_state_e;
endpackage : sbp_pkg

// ==== src/sbp_brake_sequencer.sv ====
// Servo holding-brake sequencer with protection enables and APB registers
// Functional notes
// - Overheat input active raises overheat fault
// - Config bit0 enables output phase-loss protection
// - Config bit1 enables input phase-loss protection
// - Config register sixteen bits, two bits used
// - Brake control active when brake output mapped
// - Brake release terminal is active low
// - Release inactive cuts brake, motor locked
// - Enable fall below 20 rpm: static, else dynamic
// - Enable rise: power motor, release brake together
// - Ignore commands until accept delay elapses
// - Static: lock at once, hold power, power off
// - Hold time applies only when brake mapped
// - Dynamic: lock when speed below threshold
// - Dynamic: lock when max wait exceeded
// - Dynamic: power stays 50 ms after lock
`timescale 1ns/1ns
module sbp_brake_sequencer
  import sbp_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES   // Cycles per millisecond tick
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Drive side
  input  wire logic        servoEnableInput,
  input  wire logic        overheatDetectInput,
  input  wire logic [15:0] filteredMotorSpeed,
  // Outputs
  output logic             brakeReleaseOutN,
  output logic             motorPowerOn,
  output logic             commandAccept,
  output logic             motorOverheatFault,
  output logic             outPhaseProtectEn,
  output logic             inPhaseProtectEn,
  output logic             irq
);

  // Whole module state
  typedef struct packed {
    logic [15:0]        phaseLoss;
    logic [15:0]        cmdDelay;
    logic [15:0]        zeroSpeed;
    logic [15:0]        holdMs;
    logic [15:0]        maxWait;
    logic               brakeMapped;
    logic [IRQ_W-1:0]   irqStat;
    logic [IRQ_W-1:0]   irqMask;
    sbp_state_e         state;
    logic               enPrev;
    logic [16:0]        tickCnt;
    logic               tick;
    logic [15:0]        msCnt;
    logic [15:0]        lockMs;
    logic               release_;
    logic               power;
    logic               accept;
    logic               fault;
    logic [31:0]        rdata;
  } sbp_state_s;

  sbp_state_s st_reg;   // Registered state
  sbp_state_s st_next;  // Next state

  // Address decode returns single-bit valid flag
  function automatic logic sbp_known(input logic [7:0] a);
    sbp_known = (a == OFS_PHASE_LOSS) || (a == OFS_CMD_DELAY) || (a == OFS_ZERO_SPEED)
             || (a == OFS_HOLD) || (a == OFS_MAX_WAIT) || (a == OFS_CONTROL)
             || (a == OFS_STATUS) || (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK);
  endfunction : sbp_known

  logic             apbWr;     // Write access phase
  logic             apbRd;     // Read setup phase
  logic             enRise;    // Enable rising edge
  logic             enFall;    // Enable falling edge
  logic [15:0]      holdSel;   // Hold time in effect
  logic [IRQ_W-1:0] irqEv;     // Events this cycle

  assign apbWr  = psel && penable && pwrite && sbp_known(paddr);
  assign apbRd  = psel && !penable && !pwrite;
  assign enRise = servoEnableInput && !st_reg.enPrev;
  assign enFall = !servoEnableInput && st_reg.enPrev;

  // Next-state logic
  always_comb
  begin
    st_next       = st_reg;
    st_next.enPrev = servoEnableInput;
    irqEv         = '0;
    holdSel       = st_reg.brakeMapped ? st_reg.holdMs : 16'h0000;
    // Millisecond tick generator
    st_next.tick  = 1'b0;
    if (st_reg.tickCnt == 17'(TICK_CNT - 1))
    begin
      st_next.tickCnt = '0;
      st_next.tick    = 1'b1;
    end
    else
    begin
      st_next.tickCnt = st_reg.tickCnt + 17'd1;
    end
    // Overheat fault follows input
    if (overheatDetectInput)
    begin
      st_next.fault = 1'b1;
      irqEv[0]      = !st_reg.fault;
    end
    else
    begin
      st_next.fault = 1'b0;
    end
    // Sequencer
    case (st_reg.state)
      ST_OFF:
      begin
        if (enRise)
        begin
          st_next.state    = ST_ON;
          st_next.power    = 1'b1;
          st_next.release_ = st_reg.brakeMapped;
          st_next.msCnt    = '0;
          st_next.accept   = 1'b0;
        end
      end
      ST_ON:
      begin
        // Command gate opens after delay
        if (!st_reg.accept && st_reg.tick)
        begin
          if (st_reg.msCnt + 16'd1 >= st_reg.cmdDelay)
          begin
            st_next.accept = 1'b1;
            irqEv[2]       = 1'b1;
          end
          else
          begin
            st_next.msCnt = st_reg.msCnt + 16'd1;
          end
        end
        if (!st_reg.accept && st_reg.cmdDelay == 16'h0000)
        begin
          st_next.accept = 1'b1;
        end
        if (enFall)
        begin
          st_next.accept = 1'b0;
          st_next.msCnt  = '0;
          if (filteredMotorSpeed < 16'(STATIC_RPM))
          begin
            st_next.state    = ST_HOLD;
            st_next.release_ = 1'b0;
            st_next.lockMs   = holdSel;
            irqEv[1]         = 1'b1;
          end
          else
          begin
            st_next.state = ST_DYNWAIT;
          end
        end
      end
      ST_DYNWAIT:
      begin
        if (st_reg.tick)
        begin
          st_next.msCnt = st_reg.msCnt + 16'd1;
        end
        if (filteredMotorSpeed < st_reg.zeroSpeed
            || (st_reg.tick && st_reg.msCnt >= st_reg.maxWait))
        begin
          st_next.state    = ST_HOLD;
          st_next.release_ = 1'b0;
          st_next.lockMs   = 16'(DYN_HOLD_MS);
          st_next.msCnt    = '0;
          irqEv[1]         = 1'b1;
        end
      end
      ST_HOLD:
      begin
        // Power held after lock, then removed
        if (st_reg.msCnt >= st_reg.lockMs)
        begin
          st_next.power = 1'b0;
          st_next.state = ST_OFF;
          st_next.msCnt = '0;
        end
        else if (st_reg.tick)
        begin
          st_next.msCnt = st_reg.msCnt + 16'd1;
        end
      end
      default:
      begin
        st_next.state = ST_OFF;
      end
    endcase
    // APB writes
    if (apbWr)
    begin
      if (paddr == OFS_PHASE_LOSS)
      begin
        st_next.phaseLoss = pwdata[15:0];
      end
      else if (paddr == OFS_CMD_DELAY)
      begin
        st_next.cmdDelay = pwdata[15:0];
      end
      else if (paddr == OFS_ZERO_SPEED)
      begin
        st_next.zeroSpeed = pwdata[15:0];
      end
      else if (paddr == OFS_HOLD)
      begin
        st_next.holdMs = pwdata[15:0];
      end
      else if (paddr == OFS_MAX_WAIT)
      begin
        st_next.maxWait = pwdata[15:0];
      end
      else if (paddr == OFS_CONTROL)
      begin
        st_next.brakeMapped = pwdata[BIT_BRAKE_MAP];
      end
      else if (paddr == OFS_IRQ_MASK)
      begin
        st_next.irqMask = pwdata[IRQ_W-1:0];
      end
    end
    // Sticky status: set wins over write-one clear
    if (apbWr && paddr == OFS_IRQ_STATUS)
    begin
      st_next.irqStat = (st_reg.irqStat & ~pwdata[IRQ_W-1:0]) | irqEv;
    end
    else
    begin
      st_next.irqStat = st_reg.irqStat | irqEv;
    end
    // Read data captured in setup
    if (apbRd)
    begin
      if (paddr == OFS_PHASE_LOSS)
      begin
        st_next.rdata = {16'h0000, st_reg.phaseLoss};
      end
      else if (paddr == OFS_CMD_DELAY)
      begin
        st_next.rdata = {16'h0000, st_reg.cmdDelay};
      end
      else if (paddr == OFS_ZERO_SPEED)
      begin
        st_next.rdata = {16'h0000, st_reg.zeroSpeed};
      end
      else if (paddr == OFS_HOLD)
      begin
        st_next.rdata = {16'h0000, st_reg.holdMs};
      end
      else if (paddr == OFS_MAX_WAIT)
      begin
        st_next.rdata = {16'h0000, st_reg.maxWait};
      end
      else if (paddr == OFS_CONTROL)
      begin
        st_next.rdata = {31'h0, st_reg.brakeMapped};
      end
      else if (paddr == OFS_STATUS)
      begin
        st_next.rdata = {25'h0, st_reg.state, st_reg.fault, st_reg.accept,
                         st_reg.power, st_reg.release_};
      end
      else if (paddr == OFS_IRQ_STATUS)
      begin
        st_next.rdata = {29'h0, st_reg.irqStat};
      end
      else if (paddr == OFS_IRQ_MASK)
      begin
        st_next.rdata = {29'h0, st_reg.irqMask};
      end
      else
      begin
        st_next.rdata = 32'h0000_0000;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_reg             <= '0;
      st_reg.phaseLoss   <= RST_PHASE_LOSS;
      st_reg.cmdDelay    <= RST_CMD_DELAY;
      st_reg.zeroSpeed   <= RST_ZERO_SPEED;
      st_reg.holdMs      <= RST_HOLD;
      st_reg.maxWait     <= RST_MAX_WAIT;
      st_reg.brakeMapped <= 1'b1;
      st_reg.state       <= ST_OFF;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign prdata             = st_reg.rdata;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && !sbp_known(paddr);
  assign brakeReleaseOutN   = !st_reg.release_;
  assign motorPowerOn       = st_reg.power;
  assign commandAccept      = st_reg.accept;
  assign motorOverheatFault = st_reg.fault;
  assign outPhaseProtectEn  = st_reg.phaseLoss[BIT_OUT_PHASE];
  assign inPhaseProtectEn   = st_reg.phaseLoss[BIT_IN_PHASE];
  assign irq                = |(st_reg.irqStat & st_reg.irqMask);

  // Assertions
  // Fault input reaches the fault output
  a_overheat_fault: assert property (@(posedge clk_sys) disable iff (rst)
    overheatDetectInput |=> motorOverheatFault) else $error("overheat not raised");
  // Register writes reach the protection enables
  a_out_phase_en: assert property (@(posedge clk_sys) disable iff (rst)
    (apbWr && paddr == OFS_PHASE_LOSS)
      |=> (outPhaseProtectEn == $past(pwdata[BIT_OUT_PHASE])))
    else $error("out phase mismatch");
  a_in_phase_en: assert property (@(posedge clk_sys) disable iff (rst)
    (apbWr && paddr == OFS_PHASE_LOSS)
      |=> (inPhaseProtectEn == $past(pwdata[BIT_IN_PHASE])))
    else $error("in phase mismatch");
  a_phase_width: assert property (@(posedge clk_sys) disable iff (rst)
    (apbWr && paddr == OFS_PHASE_LOSS)
      |=> (st_reg.phaseLoss == $past(pwdata[15:0]))) else $error("phase width wrong");
  // Enable rise: power and release together when brake mapped, power only when not
  a_rise_release: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.state == ST_OFF && enRise && st_reg.brakeMapped)
      |=> (motorPowerOn && !brakeReleaseOutN)) else $error("rise not released");
  a_rise_nomap: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.state == ST_OFF && enRise && !st_reg.brakeMapped)
      |=> (motorPowerOn && brakeReleaseOutN)) else $error("unmapped brake released");
  // Brake only released while the motor is energized
  a_release_powered: assert property (@(posedge clk_sys) disable iff (rst)
    !brakeReleaseOutN |-> motorPowerOn) else $error("brake released unpowered");
  // Stop sequences
  a_static_lock: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.state == ST_ON && enFall && filteredMotorSpeed < 16'd20)
      |=> (brakeReleaseOutN && motorPowerOn)) else $error("static lock late");
  a_hold_unmapped: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.state == ST_ON && enFall && filteredMotorSpeed < 16'd20 && !st_reg.brakeMapped)
      |=> ##1 !motorPowerOn) else $error("hold applied unmapped");
  a_dyn_speed_lock: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.state == ST_DYNWAIT && filteredMotorSpeed < st_reg.zeroSpeed)
      |=> brakeReleaseOutN) else $error("dynamic lock late");
  a_max_wait_lock: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg.state == ST_DYNWAIT && st_reg.tick && st_reg.msCnt >= st_reg.maxWait)
      |=> brakeReleaseOutN) else $error("max wait lock late");
  a_lock_with_power: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(brakeReleaseOutN) |-> motorPowerOn) else $error("power cut at lock");
  a_accept_gate: assert property (@(posedge clk_sys) disable iff (rst)
    commandAccept |-> (motorPowerOn && st_reg.state == ST_ON)) else $error("accept early");
  // Tick is a one-cycle strobe; needs TICK_CNT of two or more
  a_tick_single: assert property (@(posedge clk_sys) disable iff (rst)
    st_reg.tick |=> !st_reg.tick) else $error("tick too long");

endmodule : sbp_brake_sequencer

// ==== tb/sbp_host_model.sv ====
// Host controller model that drives the servo enable line
`timescale 1ns/1ns
module sbp_host_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Bench request and device answer
  input  wire logic enReq,
  input  wire logic commandAccept,
  // Host outputs
  output logic      servoEnableInput,
  output logic      cmdIssued
);
  // Enable follows the request; motion is sent only once accepted
  always_ff @(posedge clk_sys)
  begin
    servoEnableInput <= rst ? 1'b0 : enReq;
    cmdIssued        <= !rst && enReq && commandAccept;
  end
endmodule : sbp_host_model

// ==== tb/test_sbp_brake_sequencer.sv ====
// Self-checking bench for the brake sequencer
`timescale 1ns/1ns
module test_sbp_brake_sequencer;
  import sbp_pkg::*;
  localparam int TK = 10; // Cycles per tick, kept short
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        enReq, servoEnableInput, overheatDetectInput;
  logic [15:0] filteredMotorSpeed;
  logic        brakeReleaseOutN, motorPowerOn, commandAccept, motorOverheatFault;
  logic        outPhaseProtectEn, inPhaseProtectEn, irq, cmdIssued;
  int          error_cnt, checks, n;

  // Device and host
  sbp_brake_sequencer #(.TICK_CNT(TK)) u_sbp_brake_sequencer (.clk_sys, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .servoEnableInput,
    .overheatDetectInput, .filteredMotorSpeed, .brakeReleaseOutN, .motorPowerOn,
    .commandAccept, .motorOverheatFault, .outPhaseProtectEn, .inPhaseProtectEn, .irq);
  sbp_host_model u_sbp_host_model (.clk_sys, .rst, .enReq, .commandAccept,
    .servoEnableInput, .cmdIssued);

  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Cycle count compare
  task automatic rng(input int got, input int lo, input int hi, input string m);
    checks++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s took %0d", $time, m, got);
    end
  endtask : rng

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rdc

  // Select an output to watch
  function automatic logic pick(input int s);
    case (s)
      0: pick = motorPowerOn;
      1: pick = brakeReleaseOutN;
      2: pick = commandAccept;
      default: pick = motorOverheatFault;
    endcase
  endfunction : pick

  // Bounded wait for an output level, cycles left in n
  task automatic wt(input int s, input logic v);
    n = 0;
    while (pick(s) !== v && n < 2000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(pick(s), v, "wait");
  endtask : wt

  // Reset values, protection bits, unmapped access
  task automatic t_regs;
    chk({brakeReleaseOutN, motorPowerOn}, 32'h2, "rst outs");
    rdc(OFS_PHASE_LOSS, 32'h3, "phase rst");
    rdc(OFS_CMD_DELAY, 32'hfa, "delay rst");
    rdc(OFS_ZERO_SPEED, 32'h1e, "zero rst");
    rdc(OFS_HOLD, 32'h96, "hold rst");
    rdc(OFS_MAX_WAIT, 32'h1f4, "wait rst");
    chk({inPhaseProtectEn, outPhaseProtectEn}, 32'h3, "prot rst");
    wr(OFS_PHASE_LOSS, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({inPhaseProtectEn, outPhaseProtectEn}, 32'h1, "out only");
    wr(OFS_PHASE_LOSS, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk({inPhaseProtectEn, outPhaseProtectEn}, 32'h2, "in only");
    wr(OFS_PHASE_LOSS, 32'hffffffff);
    rdc(OFS_PHASE_LOSS, 32'hffff, "width");
    wr(OFS_PHASE_LOSS, 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("test regs done");
  endtask : t_regs

  // Overheat fault and its interrupt
  task automatic t_heat;
    wr(OFS_IRQ_MASK, 32'h1);
    overheatDetectInput <= 1'b1;
    wt(3, 1'b1);
    rng(n, 0, 3, "fault");
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1, "irq on");
    overheatDetectInput <= 1'b0;
    wt(3, 1'b0);
    wr(OFS_IRQ_STATUS, 32'h7);
    rdc(OFS_IRQ_STATUS, 32'h0, "irq clr");
    chk(irq, 1'b0, "irq off");
    $display("test heat done");
  endtask : t_heat

  // Static stop below the speed limit
  task automatic t_static;
    wr(OFS_CMD_DELAY, 32'h3);
    wr(OFS_HOLD, 32'h4);
    filteredMotorSpeed <= 16'h0013;
    enReq <= 1'b1;
    wt(0, 1'b1);
    chk({brakeReleaseOutN, commandAccept}, 32'h0, "release with power");
    chk(cmdIssued, 1'b0, "cmd in delay");
    wt(2, 1'b1);
    rng(n, 2 * TK, 3 * TK + 3, "accept delay");
    enReq <= 1'b0;
    wt(1, 1'b1);
    rng(n, 0, 4, "lock at once");
    chk(motorPowerOn, 1'b1, "power held");
    wt(0, 1'b0);
    rng(n, 3 * TK, 4 * TK + 3, "hold");
    rdc(OFS_IRQ_STATUS, 32'h6, "events");
    wr(OFS_IRQ_STATUS, 32'h6);
    $display("test static done");
  endtask : t_static

  // Dynamic stop ended by the zero-speed threshold
  task automatic t_dyn;
    filteredMotorSpeed <= 16'd30;
    enReq <= 1'b1;
    wt(2, 1'b1);
    enReq <= 1'b0;
    @(posedge clk_sys);
    // Speed right at the limit when the enable fall is seen
    filteredMotorSpeed <= 16'd20;
    @(posedge clk_sys);
    filteredMotorSpeed <= 16'd30;
    repeat (8) @(posedge clk_sys);
    chk(brakeReleaseOutN, 1'b0, "dyn wait");
    filteredMotorSpeed <= 16'd29;
    wt(1, 1'b1);
    rng(n, 0, 3, "zero lock");
    wt(0, 1'b0);
    rng(n, (DYN_HOLD_MS - 1) * TK, DYN_HOLD_MS * TK + 3, "dyn hold");
    $display("test dyn done");
  endtask : t_dyn

  // Dynamic stop ended by the wait limit
  task automatic t_max;
    wr(OFS_MAX_WAIT, 32'h5);
    filteredMotorSpeed <= 16'd100;
    enReq <= 1'b1;
    wt(2, 1'b1);
    enReq <= 1'b0;
    wt(1, 1'b1);
    rng(n, 5 * TK, 6 * TK + 4, "max wait");
    wt(0, 1'b0);
    $display("test max done");
  endtask : t_max

  // Brake output not mapped
  task automatic t_nomap;
    wr(OFS_CONTROL, 32'h0);
    filteredMotorSpeed <= 16'd0;
    enReq <= 1'b1;
    wt(0, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk(brakeReleaseOutN, 1'b1, "no brake");
    enReq <= 1'b0;
    wt(0, 1'b0);
    rng(n, 0, 5, "no hold");
    wr(OFS_CONTROL, 32'h1);
    $display("test nomap done");
  endtask : t_nomap

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // Watchdog
  initial
  begin
    #(8 * 20000);
    error_cnt++;
    test_done;
  end

  // Main sequence
  initial
  begin
    error_cnt = 0;
    checks = 0;
    rst = 1'b1;
    {psel, penable, pwrite, enReq, overheatDetectInput} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    filteredMotorSpeed = 16'h0000;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_heat;
    t_static;
    t_dyn;
    t_max;
    t_nomap;
    test_done;
  end
endmodule : test_sbp_brake_sequencer
